/* File: include/tap_pkg.sv */
// Shared constants and types of the boundary-scan port and its controller
package tap_pkg;
    localparam int IR_WIDTH = 3;
    localparam int BSR_WIDTH = 69;
    localparam int ID_WIDTH = 32;
    localparam int BSR_PRESET_BIT = 50;
    localparam int RESET_TMS_EDGES = 5;
    localparam int TCK_DIV_HALF = 4;
    localparam int BUF_DEPTH = 2;
    localparam int SHIFT_CNT_WIDTH = 7;
    localparam logic [2:0] IR_EXT_TEST = 3'h0;
    localparam logic [2:0] IR_IDENT = 3'h1;
    localparam logic [2:0] IR_HIZ_SAMPLE = 3'h2;
    localparam logic [2:0] IR_SAMPLE_PRELOAD = 3'h4;
    localparam logic [2:0] IR_BYPASS = 3'h7;
    localparam logic [1:0] IR_CAPTURE_PATTERN = 2'h1;
    // Identity fields: arbitrary neutral values
    localparam logic [2:0] ID_REVISION = 3'h0;
    localparam logic [16:0] ID_DEVICE = 17'h00001;
    localparam logic [10:0] ID_MAKER = 11'h001;
    localparam logic [31:0] ID_VALUE = {ID_REVISION, ID_DEVICE, ID_MAKER, 1'b1};

    typedef enum logic [3:0] {
        ST_RESET = 4'h0,
        ST_IDLE = 4'h1,
        ST_SEL_DR = 4'h2,
        ST_CAP_DR = 4'h3,
        ST_SHIFT_DR = 4'h4,
        ST_EXIT1_DR = 4'h5,
        ST_PAUSE_DR = 4'h6,
        ST_EXIT2_DR = 4'h7,
        ST_UPD_DR = 4'h8,
        ST_SEL_IR = 4'h9,
        ST_CAP_IR = 4'hA,
        ST_SHIFT_IR = 4'hB,
        ST_EXIT1_IR = 4'hC,
        ST_PAUSE_IR = 4'hD,
        ST_EXIT2_IR = 4'hE,
        ST_UPD_IR = 4'hF
    } tap_state_type;

    // Standard next-state table of the test access machine
    function automatic tap_state_type tap_next(input tap_state_type s, input logic tms);
        tap_state_type n;
        n = ST_RESET;
        unique case (s)
            ST_RESET: n = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: n = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: n = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: n = tms ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: n = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: n = tms ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: n = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: n = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: n = tms ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: n = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: n = tms ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: n = tms ? ST_SEL_DR : ST_IDLE;
        endcase
        return n;
    endfunction
endpackage

/* File: include/tap_link_if.sv */
// Scan link between the external controller and the SRAM test port
interface tap_link_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    modport controller (output tck, output tms, output tdi, input tdo, input tdo_oe);
    modport port (input tck, input tms, input tdi, output tdo, output tdo_oe);
endinterface

/* File: hw/sram_boundary_scan_tap.sv */
// SRAM boundary-scan test port, sampling the link on its own clock
module sram_boundary_scan_tap (
    input wire logic core_clk,
    input wire logic reset,
    tap_link_if.port link,
    input wire logic [tap_pkg::BSR_WIDTH-1:0] ring_in,
    output logic [tap_pkg::BSR_WIDTH-1:0] cell_out,
    output logic drive_cells,
    output logic sram_outputs_off,
    output logic [tap_pkg::IR_WIDTH-1:0] active_instr
);
    import tap_pkg::*;

    logic [2:0] tck_sync_reg, tck_sync_next;
    logic [1:0] tms_sync_reg, tms_sync_next;
    logic [1:0] tdi_sync_reg, tdi_sync_next;
    logic tck_rise, tck_fall;
    tap_state_type state_reg, state_next;
    logic [IR_WIDTH-1:0] ir_shift_reg, ir_shift_next;
    logic [IR_WIDTH-1:0] ir_reg, ir_next;
    logic bypass_reg, bypass_next;
    logic [ID_WIDTH-1:0] id_reg, id_next;
    logic [BSR_WIDTH-1:0] bsr_reg, bsr_next;
    logic [BSR_WIDTH-1:0] cell_reg, cell_next;
    logic tdo_reg, tdo_next;
    logic oe_reg, oe_next;
    logic drive_reg, drive_next;
    logic off_reg, off_next;
    logic serial_bit;

    // Link pins come from another domain; tck_sync_reg[2] is the edge history
    always_comb begin
        tck_sync_next = {tck_sync_reg[1:0], link.tck};
        tms_sync_next = {tms_sync_reg[0], link.tms};
        tdi_sync_next = {tdi_sync_reg[0], link.tdi};
    end
    assign tck_rise = tck_sync_reg[1] && !tck_sync_reg[2];
    assign tck_fall = !tck_sync_reg[1] && tck_sync_reg[2];

    always_comb begin
        state_next = state_reg;
        ir_shift_next = ir_shift_reg;
        ir_next = ir_reg;
        bypass_next = bypass_reg;
        id_next = id_reg;
        bsr_next = bsr_reg;
        cell_next = cell_reg;
        if (tck_rise) begin
            state_next = tap_next(state_reg, tms_sync_reg[1]);
            unique case (state_reg)
                ST_RESET: ir_next = IR_IDENT;
                ST_CAP_IR: ir_shift_next = {ir_shift_reg[IR_WIDTH-1:2], IR_CAPTURE_PATTERN};
                ST_SHIFT_IR: ir_shift_next = {tdi_sync_reg[1], ir_shift_reg[IR_WIDTH-1:1]};
                ST_UPD_IR: ir_next = ir_shift_reg;
                ST_CAP_DR: begin
                    unique case (ir_reg)
                        IR_IDENT: id_next = ID_VALUE;
                        IR_EXT_TEST, IR_HIZ_SAMPLE, IR_SAMPLE_PRELOAD: begin
                            // Snapshot with the preset bit forced high; SRAM pins are never disturbed here
                            bsr_next = ring_in;
                            bsr_next[BSR_PRESET_BIT] = 1'b1;
                        end
                        default: bypass_next = 1'b0;
                    endcase
                end
                ST_SHIFT_DR: begin
                    unique case (ir_reg)
                        IR_IDENT: id_next = {tdi_sync_reg[1], id_reg[ID_WIDTH-1:1]};
                        IR_EXT_TEST, IR_HIZ_SAMPLE, IR_SAMPLE_PRELOAD:
                            bsr_next = {tdi_sync_reg[1], bsr_reg[BSR_WIDTH-1:1]};
                        default: bypass_next = tdi_sync_reg[1];
                    endcase
                end
                ST_UPD_DR: begin
                    if (ir_reg == IR_SAMPLE_PRELOAD || ir_reg == IR_EXT_TEST) begin
                        cell_next = bsr_reg;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Reserved codes fall to bypass, so the chain never breaks
    always_comb begin
        unique case (ir_reg)
            IR_IDENT: serial_bit = id_reg[0];
            IR_EXT_TEST, IR_HIZ_SAMPLE, IR_SAMPLE_PRELOAD: serial_bit = bsr_reg[0];
            default: serial_bit = bypass_reg;
        endcase
    end

    always_comb begin
        tdo_next = tdo_reg;
        oe_next = oe_reg;
        if (tck_fall) begin
            oe_next = (state_reg == ST_SHIFT_IR) || (state_reg == ST_SHIFT_DR);
            tdo_next = (state_reg == ST_SHIFT_IR) ? ir_shift_reg[0] : serial_bit;
        end
        drive_next = (ir_reg == IR_EXT_TEST);
        off_next = (ir_reg == IR_HIZ_SAMPLE) || (ir_reg == IR_EXT_TEST);
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tck_sync_reg <= 3'h0;
            tms_sync_reg <= 2'h3;
            tdi_sync_reg <= 2'h3;
            state_reg <= ST_RESET;
            ir_shift_reg <= IR_IDENT;
            ir_reg <= IR_IDENT;
            bypass_reg <= 1'b0;
            id_reg <= ID_VALUE;
            bsr_reg <= {BSR_WIDTH{1'b0}};
            cell_reg <= {BSR_WIDTH{1'b0}};
            tdo_reg <= 1'b0;
            oe_reg <= 1'b0;
            drive_reg <= 1'b0;
            off_reg <= 1'b0;
        end else begin
            tck_sync_reg <= tck_sync_next;
            tms_sync_reg <= tms_sync_next;
            tdi_sync_reg <= tdi_sync_next;
            state_reg <= state_next;
            ir_shift_reg <= ir_shift_next;
            ir_reg <= ir_next;
            bypass_reg <= bypass_next;
            id_reg <= id_next;
            bsr_reg <= bsr_next;
            cell_reg <= cell_next;
            tdo_reg <= tdo_next;
            oe_reg <= oe_next;
            drive_reg <= drive_next;
            off_reg <= off_next;
        end
    end

    assign link.tdo = tdo_reg;
    assign link.tdo_oe = oe_reg;
    assign cell_out = cell_reg;
    assign drive_cells = drive_reg;
    assign sram_outputs_off = off_reg;
    assign active_instr = ir_reg;
endmodule

/* File: hw/scan_controller.sv */
// External scan controller: walks the test port and shifts words through it
module scan_controller (
    input wire logic core_clk,
    input wire logic reset,
    tap_link_if.controller link,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_is_ir,
    input wire logic [tap_pkg::SHIFT_CNT_WIDTH-1:0] req_len,
    input wire logic [tap_pkg::BSR_WIDTH-1:0] req_data,
    input wire logic req_reset,
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic [tap_pkg::BSR_WIDTH-1:0] rsp_data
);
    import tap_pkg::*;

    typedef enum logic [1:0] {
        C_IDLE = 2'h0,
        C_RUN = 2'h1,
        C_PUSH = 2'h2
    } ctl_state_type;

    ctl_state_type st_reg, st_next;
    logic [2:0] div_reg, div_next;
    logic tck_reg, tck_next;
    logic tms_reg, tms_next;
    logic tdi_reg, tdi_next;
    logic [1:0] tdo_sync_reg, tdo_sync_next;
    logic [15:0] tms_seq_reg, tms_seq_next;
    logic [6:0] steps_reg, steps_next;
    logic [6:0] shift_left_reg, shift_left_next;
    logic [6:0] lead_reg, lead_next;
    logic [BSR_WIDTH-1:0] out_reg, out_next;
    logic [BSR_WIDTH-1:0] in_reg, in_next;
    logic [6:0] len_reg, len_next;
    logic [BSR_WIDTH-1:0] buf_mem_reg [BUF_DEPTH], buf_mem_next [BUF_DEPTH];
    logic [1:0] buf_cnt_reg, buf_cnt_next;
    logic buf_wr_reg, buf_wr_next;
    logic buf_rd_reg, buf_rd_next;
    logic half_tick, buf_full;

    assign half_tick = (div_reg == 3'(TCK_DIV_HALF - 1));
    assign buf_full = (buf_cnt_reg == 2'(BUF_DEPTH));

    always_comb begin
        st_next = st_reg;
        div_next = half_tick ? 3'h0 : div_reg + 3'h1;
        tck_next = tck_reg;
        tms_next = tms_reg;
        tdi_next = tdi_reg;
        tdo_sync_next = {tdo_sync_reg[0], link.tdo};
        tms_seq_next = tms_seq_reg;
        steps_next = steps_reg;
        shift_left_next = shift_left_reg;
        lead_next = lead_reg;
        out_next = out_reg;
        in_next = in_reg;
        len_next = len_reg;
        buf_mem_next = buf_mem_reg;
        buf_cnt_next = buf_cnt_reg;
        buf_wr_next = buf_wr_reg;
        buf_rd_next = buf_rd_reg;
        unique case (st_reg)
            C_IDLE: begin
                if (req_valid && div_reg == 3'h0 && !tck_reg) begin
                    st_next = C_RUN;
                    out_next = req_data;
                    in_next = {BSR_WIDTH{1'b0}};
                    len_next = req_len;
                    if (req_reset) begin
                        // Five TMS-high edges, then one low into idle
                        tms_seq_next = 16'h001F;
                        steps_next = 7'(RESET_TMS_EDGES + 1);
                        shift_left_next = 7'h0;
                        lead_next = 7'h0;
                    end else begin
                        // Idle: 1 to select-DR, (1 to select-IR), 0 capture, 0 shift
                        tms_seq_next = req_is_ir ? 16'h0003 : 16'h0001;
                        lead_next = req_is_ir ? 7'h4 : 7'h3;
                        steps_next = lead_next;
                        shift_left_next = req_len;
                    end
                end
            end
            C_RUN: begin
                if (half_tick) begin
                    tck_next = !tck_reg;
                    if (tck_reg) begin
                        // Take the bit shown just before the previous rise; the two sync flops make
                        // the copy at that rise stale, so it is read here once it has settled
                        if (shift_left_reg != len_reg &&
                            (lead_reg != 7'h7F || steps_reg == 7'h2)) begin
                            in_next = {tdo_sync_reg[1], in_reg[BSR_WIDTH-1:1]};
                        end
                        // Falling edge: present TMS and TDI for the next rise
                        if (steps_reg != 7'h0) begin
                            tms_next = tms_seq_reg[0];
                            tms_seq_next = {1'b0, tms_seq_reg[15:1]};
                            steps_next = steps_reg - 7'h1;
                        end else if (shift_left_reg != 7'h0) begin
                            tdi_next = out_reg[0];
                            out_next = {1'b0, out_reg[BSR_WIDTH-1:1]};
                            // Last bit leaves Shift with TMS high, then update, idle
                            tms_next = (shift_left_reg == 7'h1);
                            shift_left_next = shift_left_reg - 7'h1;
                            if (shift_left_reg == 7'h1) begin
                                tms_seq_next = 16'h0001;
                                steps_next = 7'h2;
                                lead_next = 7'h7F;
                            end
                        end else begin
                            st_next = C_PUSH;
                        end
                    end
                end
            end
            C_PUSH: begin
                // Stall here while the buffer is full
                if (!buf_full) begin
                    buf_wr_next = !buf_wr_reg;
                    buf_mem_next[buf_wr_reg] = in_reg >> (7'(BSR_WIDTH) - len_reg);
                    buf_cnt_next = buf_cnt_reg + 2'h1;
                    st_next = C_IDLE;
                end
            end
            default: st_next = C_IDLE;
        endcase
        if (rsp_valid && rsp_ready) begin
            buf_rd_next = !buf_rd_reg;
            buf_cnt_next = buf_cnt_next - 2'h1;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_reg <= C_IDLE;
            div_reg <= 3'h0;
            tck_reg <= 1'b0;
            tms_reg <= 1'b1;
            tdi_reg <= 1'b1;
            tdo_sync_reg <= 2'h0;
            tms_seq_reg <= 16'h0000;
            steps_reg <= 7'h0;
            shift_left_reg <= 7'h0;
            lead_reg <= 7'h0;
            out_reg <= {BSR_WIDTH{1'b0}};
            in_reg <= {BSR_WIDTH{1'b0}};
            len_reg <= 7'h0;
            buf_mem_reg <= '{default: '0};
            buf_cnt_reg <= 2'h0;
            buf_wr_reg <= 1'b0;
            buf_rd_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            div_reg <= div_next;
            tck_reg <= tck_next;
            tms_reg <= tms_next;
            tdi_reg <= tdi_next;
            tdo_sync_reg <= tdo_sync_next;
            tms_seq_reg <= tms_seq_next;
            steps_reg <= steps_next;
            shift_left_reg <= shift_left_next;
            lead_reg <= lead_next;
            out_reg <= out_next;
            in_reg <= in_next;
            len_reg <= len_next;
            buf_mem_reg <= buf_mem_next;
            buf_cnt_reg <= buf_cnt_next;
            buf_wr_reg <= buf_wr_next;
            buf_rd_reg <= buf_rd_next;
        end
    end

    assign link.tck = tck_reg;
    assign link.tms = tms_reg;
    assign link.tdi = tdi_reg;
    assign req_ready = (st_reg == C_IDLE) && div_reg == 3'h0 && !tck_reg;
    assign rsp_valid = (buf_cnt_reg != 2'h0);
    assign rsp_data = buf_mem_reg[buf_rd_reg];
endmodule

/* File: test/tap_link_asserts.sv */
// Protocol checks on the scan link between the controller and the test port
module tap_link_asserts (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tck_d_reg;
    logic tck_d_next;
    logic last_tms_reg;
    logic last_tms_next;
    logic [2:0] hi_cnt_reg;
    logic [2:0] hi_cnt_next;
    logic [2:0] rise_cnt_reg;
    logic [2:0] rise_cnt_next;

    // Counters saturate so long idle runs never wrap into a false window
    always_comb begin
        tck_d_next = tck;
        last_tms_next = last_tms_reg;
        hi_cnt_next = hi_cnt_reg;
        rise_cnt_next = rise_cnt_reg;
        if (tck && !tck_d_reg) begin
            last_tms_next = tms;
            if (!tms) begin
                hi_cnt_next = 3'h0;
            end else if (hi_cnt_reg != 3'h5) begin
                hi_cnt_next = hi_cnt_reg + 3'h1;
            end
            if (rise_cnt_reg != 3'h7) begin
                rise_cnt_next = rise_cnt_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tck_d_reg <= 1'b0;
            last_tms_reg <= 1'b1;
            hi_cnt_reg <= 3'h0;
            rise_cnt_reg <= 3'h0;
        end else begin
            tck_d_reg <= tck_d_next;
            last_tms_reg <= last_tms_next;
            hi_cnt_reg <= hi_cnt_next;
            rise_cnt_reg <= rise_cnt_next;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    AST_TMS_RESET_RELEASES_TDO: assert property (hi_cnt_reg == 3'h5 |-> !tdo_oe)
        else $error("serial output driven after five TMS-high edges");
    AST_POWERUP_TDO_RELEASED: assert property (rise_cnt_reg < 3'h4 |-> !tdo_oe)
        else $error("serial output driven too soon after reset");
    AST_TDO_CHANGES_ON_FALL: assert property ($changed(tdo) |-> !tck && !$past(tck))
        else $error("serial output changed while test clock high");
    AST_OE_CHANGES_ON_FALL: assert property ($changed(tdo_oe) |-> !tck)
        else $error("output enable changed while test clock high");
    AST_SETUP_BEFORE_RISE: assert property ($rose(tck) |-> $stable(tms) && $stable(tdi))
        else $error("mode or data moved at test clock rise");
    AST_HOLD_AFTER_RISE: assert property ($rose(tck) |=> $stable(tms) && $stable(tdi))
        else $error("mode or data moved right after test clock rise");
    AST_TCK_HIGH_TIME: assert property ($rose(tck) |-> tck [*4] ##1 !tck)
        else $error("test clock high time wrong");
    AST_TCK_LOW_TIME: assert property ($fell(tck) |-> !tck [*4])
        else $error("test clock low time too short");
    AST_OE_ON_ENTERS_SHIFT: assert property ($rose(tdo_oe) |-> !last_tms_reg)
        else $error("output enabled without a mode-low step");
    AST_OE_OFF_LEAVES_SHIFT: assert property ($fell(tdo_oe) |-> last_tms_reg)
        else $error("output released without a mode-high step");
endmodule

/* File: test/sram_boundary_scan_tap_bench.sv */
// Self-checking bench: scan controller driving the SRAM test port over the link
`define CHECK(got, exp) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        fails++; \
        $display("MISMATCH at %0t: got %0h expected %0h", $time, (got), (exp)); \
    end \
end

module sram_boundary_scan_tap_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import tap_pkg::*;
    localparam int WAIT_LIMIT = 4000;
    localparam logic [BSR_WIDTH-1:0] PAT_RING = 69'h1_2345_6789_ABCD_EF5A;
    localparam logic [BSR_WIDTH-1:0] PAT_PRE = 69'h0_F00D_CAFE_3C3C_9669;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic req_valid = 1'b0;
    logic req_ready;
    logic req_is_ir = 1'b0;
    logic [SHIFT_CNT_WIDTH-1:0] req_len = 7'h01;
    logic [BSR_WIDTH-1:0] req_data = '0;
    logic req_reset = 1'b0;
    logic rsp_valid;
    logic rsp_ready = 1'b0;
    logic [BSR_WIDTH-1:0] rsp_data;
    logic [BSR_WIDTH-1:0] ring_in = PAT_RING;
    logic [BSR_WIDTH-1:0] cell_out;
    logic drive_cells;
    logic sram_outputs_off;
    logic [IR_WIDTH-1:0] active_instr;
    int fails = 0;
    int check_count = 0;

    tap_link_if link_inst ();
    sram_boundary_scan_tap sram_boundary_scan_tap_inst (.core_clk(core_clk), .reset(reset),
        .link(link_inst), .ring_in(ring_in), .cell_out(cell_out), .drive_cells(drive_cells),
        .sram_outputs_off(sram_outputs_off), .active_instr(active_instr));
    scan_controller scan_controller_inst (.core_clk(core_clk), .reset(reset), .link(link_inst),
        .req_valid(req_valid), .req_ready(req_ready), .req_is_ir(req_is_ir), .req_len(req_len),
        .req_data(req_data), .req_reset(req_reset), .rsp_valid(rsp_valid),
        .rsp_ready(rsp_ready), .rsp_data(rsp_data));
    tap_link_asserts tap_link_asserts_inst (.core_clk(core_clk), .reset(reset),
        .tck(link_inst.tck), .tms(link_inst.tms), .tdi(link_inst.tdi), .tdo(link_inst.tdo),
        .tdo_oe(link_inst.tdo_oe));

    always #20 core_clk = ~core_clk;

    // Request held from a falling edge until the rising edge that sees ready
    task automatic send(input logic ir, input logic rst, input logic [6:0] len,
                        input logic [BSR_WIDTH-1:0] d);
        int n;
        n = 0;
        @(negedge core_clk);
        req_valid = 1'b1;
        req_is_ir = ir;
        req_reset = rst;
        req_len = len;
        req_data = d;
        while (req_ready !== 1'b1 && n < WAIT_LIMIT) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= WAIT_LIMIT) begin
            fails++;
            report_and_stop();
        end
        @(negedge core_clk);
        req_valid = 1'b0;
    endtask

    task automatic recv(output logic [BSR_WIDTH-1:0] q);
        int n;
        n = 0;
        @(negedge core_clk);
        while (rsp_valid !== 1'b1 && n < WAIT_LIMIT) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= WAIT_LIMIT) begin
            fails++;
            report_and_stop();
        end
        q = rsp_data;
        rsp_ready = 1'b1;
        @(negedge core_clk);
        rsp_ready = 1'b0;
    endtask

    task automatic scan(input logic ir, input logic [6:0] len, input logic [BSR_WIDTH-1:0] d,
                        output logic [BSR_WIDTH-1:0] q);
        send(ir, 1'b0, len, d);
        recv(q);
    endtask

    // A reset walk always queues a reply in the buffer; drain it here
    task automatic tap_reset();
        logic [BSR_WIDTH-1:0] q;
        int n;
        n = 0;
        send(1'b0, 1'b1, 7'h05, '0);
        while (req_ready !== 1'b1 && n < WAIT_LIMIT) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= WAIT_LIMIT) begin
            fails++;
            report_and_stop();
        end
        repeat (4) @(negedge core_clk);
        if (rsp_valid === 1'b1) recv(q);
    endtask

    task automatic test_ident();
        logic [BSR_WIDTH-1:0] q;
        `CHECK(active_instr, IR_IDENT)
        `CHECK(link_inst.tdo_oe, 1'b0)
        tap_reset();
        scan(1'b0, 7'h20, '0, q);
        `CHECK(q[31:0], ID_VALUE)
        `CHECK(q[0], 1'b1)
    endtask

    // Every implemented code: capture pattern, pin effects, selected path
    task automatic test_codes();
        logic [BSR_WIDTH-1:0] q;
        logic [2:0] code;
        logic [7:0] exp;
        logic bsr;
        for (int c = 0; c < 8; c++) begin
            code = c[2:0];
            // Reserved codes are never loaded by the controller
            if (code == 3'h3 || code == 3'h5 || code == 3'h6) continue;
            bsr = code == IR_EXT_TEST || code == IR_HIZ_SAMPLE || code == IR_SAMPLE_PRELOAD;
            scan(1'b1, 7'h03, {66'h0, code}, q);
            `CHECK(q[1:0], IR_CAPTURE_PATTERN)
            `CHECK(active_instr, code)
            `CHECK(drive_cells, code == IR_EXT_TEST)
            `CHECK(sram_outputs_off, code == IR_EXT_TEST || code == IR_HIZ_SAMPLE)
            exp = (code == IR_IDENT) ? ID_VALUE[7:0] : (bsr ? ring_in[7:0] : 8'h4A);
            scan(1'b0, 7'h08, {61'h0, 8'hA5}, q);
            `CHECK(q[7:0], exp)
        end
    endtask

    task automatic test_preload();
        logic [BSR_WIDTH-1:0] q;
        logic [BSR_WIDTH-1:0] exp;
        // Ring held still across capture, so clock cells need not be ignored here
        ring_in[BSR_PRESET_BIT] = 1'b0;
        exp = ring_in;
        exp[BSR_PRESET_BIT] = 1'b1;
        scan(1'b1, 7'h03, {66'h0, IR_SAMPLE_PRELOAD}, q);
        `CHECK(sram_outputs_off, 1'b0)
        scan(1'b0, 7'h45, PAT_PRE, q);
        `CHECK(q, exp)
        `CHECK(cell_out, PAT_PRE)
        scan(1'b1, 7'h03, {66'h0, IR_EXT_TEST}, q);
        `CHECK(drive_cells, 1'b1)
        `CHECK(cell_out, PAT_PRE)
    endtask

    task automatic test_tms_reset();
        logic [BSR_WIDTH-1:0] q;
        scan(1'b1, 7'h03, {66'h0, IR_BYPASS}, q);
        `CHECK(active_instr, IR_BYPASS)
        tap_reset();
        `CHECK(active_instr, IR_IDENT)
    endtask

    // Receiver stalls: two replies fill the buffer, a third scan waits behind them
    task automatic test_stall();
        logic [BSR_WIDTH-1:0] q;
        scan(1'b1, 7'h03, {66'h0, IR_BYPASS}, q);
        for (int i = 1; i <= 3; i++) send(1'b0, 1'b0, 7'h08, {61'h0, 8'h11 * i[7:0]});
        for (int i = 1; i <= 3; i++) begin
            recv(q);
            `CHECK(q[7:0], {8'h11 * i[7:0]} << 1)
        end
    endtask

    task automatic test_midrun_reset();
        logic [BSR_WIDTH-1:0] q;
        send(1'b0, 1'b0, 7'h45, PAT_PRE);
        repeat (150) @(negedge core_clk);
        reset = 1'b1;
        @(negedge core_clk);
        `CHECK(link_inst.tdo_oe, 1'b0)
        `CHECK(active_instr, IR_IDENT)
        repeat (16) @(negedge core_clk);
        reset = 1'b0;
        tap_reset();
        scan(1'b0, 7'h20, '0, q);
        `CHECK(q[31:0], ID_VALUE)
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(negedge core_clk);
        reset = 1'b0;
        test_ident();
        test_codes();
        test_preload();
        test_tms_reset();
        test_stall();
        test_midrun_reset();
        report_and_stop();
    end

    // Whole run needs some 3.5k cycles; 50k means something hung
    initial begin
        #2000000;
        fails++;
        report_and_stop();
    end
endmodule
